// ### core/rtesm_pkg.sv
// package of the rx/tx event status and mask block
// assumes one aclk domain, synchronous active-low reset, axi4-lite access
//
// Overview of operation
// - tx descriptor with irq flag sets bit 7
// - good transmit attempt sets bit 6
// - rx data fifo overflow sets bit 5
// - rx engine running to idle sets bit 4
// - rx drain threshold met sets bit 3, once/packet
// - failed reception sets bit 2
// - rx descriptor with irq flag sets bit 1
// - good reception sets bit 0
// - mask bit one lets status interrupt
// - status latches regardless of mask
// - hard reset clears mask
// - soft reset clears mask too
// - mask bits 25-20, 16-0 implemented, others unused
// - reading status clears all status bits
// - bit 15 is OR of bits 25-16
// - master enable zero blocks host_irq; block_irq ignores it
package rtesm_pkg;
    localparam logic [7:0]  OFS_STATUS     = 8'h10;
    localparam logic [7:0]  OFS_MASK       = 8'h14;
    localparam logic [7:0]  OFS_MASTER_EN  = 8'h18;
    localparam logic [7:0]  OFS_EV_CLEAR   = 8'h1C;
    localparam logic [7:0]  OFS_EV_ENABLE  = 8'h20;
    localparam logic [7:0]  OFS_SOFT_RESET = 8'h24;
    localparam logic [31:0] MASK_RESET     = 32'h0000_0000;
    localparam logic [31:0] MASK_IMPL      = 32'h03F1_FFFF;
    localparam logic [31:0] HIGH_ERR_BITS  = 32'h03FF_0000;
    localparam int          HIGH_SUM_BIT   = 15;
    localparam int          NUM_EVENTS     = 32;
    localparam int          BIT_RX_GOOD    = 0;
    localparam int          BIT_RX_DESC    = 1;
    localparam int          BIT_RX_FAIL    = 2;
    localparam int          BIT_RX_EARLY   = 3;
    localparam int          BIT_RX_IDLE    = 4;
    localparam int          BIT_RX_OVF     = 5;
    localparam int          BIT_TX_GOOD    = 6;
    localparam int          BIT_TX_DESC    = 7;
    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;
    typedef enum logic {RTESM_IDLE, RTESM_RESP} rtesm_bus_state_t;
endpackage : rtesm_pkg

// ### core/rtesm_event_src.sv
// event conditioning: turns engine strobes into status set pulses
// assumes strobes other than the rx_engine_running level are single-cycle and on aclk
module rtesm_event_src (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // engine strobes
    input  wire logic        tx_desc_written,
    input  wire logic        tx_desc_irq_flag,
    input  wire logic        tx_attempt_done_ok,
    input  wire logic        rx_fifo_overflow,
    input  wire logic        rx_engine_running,
    input  wire logic        rx_drain_bytes_met,
    input  wire logic        rx_packet_start,
    input  wire logic        rx_last_desc_written,
    input  wire logic        rx_packet_ok,
    input  wire logic        rx_desc_written,
    input  wire logic        rx_desc_irq_flag,
    // set pulses
    output logic      [7:0]  set_low
);
    logic running_q;
    logic running_d;
    logic early_done_q;
    logic early_done_d;

    always_comb begin
        running_d    = rx_engine_running;
        early_done_d = early_done_q;
        if (rx_packet_start) begin
            early_done_d = 1'b0;
        end
        if (rx_drain_bytes_met) begin
            early_done_d = 1'b1;
        end
        set_low = 8'h00;
        set_low[rtesm_pkg::BIT_TX_DESC] =
            tx_desc_written & tx_desc_irq_flag;
        set_low[rtesm_pkg::BIT_TX_GOOD] = tx_attempt_done_ok;
        set_low[rtesm_pkg::BIT_RX_OVF]  = rx_fifo_overflow;
        set_low[rtesm_pkg::BIT_RX_IDLE] =
            running_q & ~rx_engine_running;
        // a second threshold hit in the same packet is swallowed
        set_low[rtesm_pkg::BIT_RX_EARLY] =
            rx_drain_bytes_met & ~early_done_q;
        set_low[rtesm_pkg::BIT_RX_FAIL] =
            rx_last_desc_written & ~rx_packet_ok;
        set_low[rtesm_pkg::BIT_RX_DESC] =
            rx_desc_written & rx_desc_irq_flag;
        set_low[rtesm_pkg::BIT_RX_GOOD] =
            rx_last_desc_written & rx_packet_ok;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            running_q    <= 1'b0;
            early_done_q <= 1'b0;
        end else begin
            running_q    <= running_d;
            early_done_q <= early_done_d;
        end
    end
endmodule : rtesm_event_src

// ### core/rtesm_top.sv
// event status, mask and interrupt output with an axi4-lite slave
// assumes engine strobes on aclk; upper status events come in as pulses
module rtesm_top (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // transmit engine strobes
    input  wire logic        tx_desc_written,
    input  wire logic        tx_desc_irq_flag,
    input  wire logic        tx_attempt_done_ok,
    // receive engine strobes
    input  wire logic        rx_fifo_overflow,
    input  wire logic        rx_engine_running,
    input  wire logic        rx_drain_bytes_met,
    input  wire logic        rx_packet_start,
    input  wire logic        rx_last_desc_written,
    input  wire logic        rx_packet_ok,
    input  wire logic        rx_desc_written,
    input  wire logic        rx_desc_irq_flag,
    // other event sources, bits 31-8 of status
    input  wire logic [31:8] upper_event_set,
    // interrupts
    output logic             host_irq,
    output logic             block_irq
);
    logic [7:0]  set_low;
    logic [31:0] ev_set;
    logic [31:0] status_q;
    logic [31:0] status_d;
    logic [31:0] status_view;
    logic [31:0] mask_q;
    logic [31:0] mask_d;
    logic        master_en_q;
    logic        master_en_d;
    logic [31:0] blk_stat_q;
    logic [31:0] blk_stat_d;
    logic [31:0] blk_en_q;
    logic [31:0] blk_en_d;
    logic        host_irq_q;
    logic        host_irq_d;
    logic        block_irq_q;
    logic        block_irq_d;
    rtesm_pkg::rtesm_bus_state_t wr_st_q;
    rtesm_pkg::rtesm_bus_state_t wr_st_d;
    rtesm_pkg::rtesm_bus_state_t rd_st_q;
    rtesm_pkg::rtesm_bus_state_t rd_st_d;
    logic        aw_held_q;
    logic        aw_held_d;
    logic        w_held_q;
    logic        w_held_d;
    logic [7:0]  awaddr_q;
    logic [7:0]  awaddr_d;
    logic [31:0] wdata_q;
    logic [31:0] wdata_d;
    logic [3:0]  wstrb_q;
    logic [3:0]  wstrb_d;
    logic [1:0]  bresp_q;
    logic [1:0]  bresp_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0]  rresp_q;
    logic [1:0]  rresp_d;
    logic        wr_go;
    logic        rd_go;
    logic [31:0] wmask;
    logic        soft_reset;

    rtesm_event_src u_event_src (
        .aclk                 (aclk),
        .aresetn              (aresetn),
        .tx_desc_written      (tx_desc_written),
        .tx_desc_irq_flag     (tx_desc_irq_flag),
        .tx_attempt_done_ok   (tx_attempt_done_ok),
        .rx_fifo_overflow     (rx_fifo_overflow),
        .rx_engine_running    (rx_engine_running),
        .rx_drain_bytes_met   (rx_drain_bytes_met),
        .rx_packet_start      (rx_packet_start),
        .rx_last_desc_written (rx_last_desc_written),
        .rx_packet_ok         (rx_packet_ok),
        .rx_desc_written      (rx_desc_written),
        .rx_desc_irq_flag     (rx_desc_irq_flag),
        .set_low              (set_low)
    );

    assign ev_set = {upper_event_set, set_low};

    // bit 15 is a pure summary, never latched on its own
    always_comb begin
        status_view = status_q;
        status_view[rtesm_pkg::HIGH_SUM_BIT] =
            |(status_q & rtesm_pkg::HIGH_ERR_BITS);
    end

    // write channel: address and data taken in either order
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        wr_st_d   = wr_st_q;
        bresp_d   = bresp_q;
        wr_go     = 1'b0;
        case (wr_st_q)
            rtesm_pkg::RTESM_IDLE: begin
                if (s_axi_awvalid && !aw_held_q) begin
                    aw_held_d = 1'b1;
                    awaddr_d  = s_axi_awaddr;
                end
                if (s_axi_wvalid && !w_held_q) begin
                    w_held_d = 1'b1;
                    wdata_d  = s_axi_wdata;
                    wstrb_d  = s_axi_wstrb;
                end
                if (aw_held_q && w_held_q) begin
                    wr_go     = 1'b1;
                    aw_held_d = 1'b0;
                    w_held_d  = 1'b0;
                    wr_st_d   = rtesm_pkg::RTESM_RESP;
                    case (awaddr_q)
                        rtesm_pkg::OFS_MASK,
                        rtesm_pkg::OFS_MASTER_EN,
                        rtesm_pkg::OFS_EV_CLEAR,
                        rtesm_pkg::OFS_EV_ENABLE,
                        rtesm_pkg::OFS_SOFT_RESET: begin
                            bresp_d = rtesm_pkg::RESP_OKAY;
                        end
                        rtesm_pkg::OFS_STATUS: begin
                            bresp_d = rtesm_pkg::RESP_OKAY;
                        end
                        default: begin
                            bresp_d = rtesm_pkg::RESP_SLVERR;
                        end
                    endcase
                end
            end
            rtesm_pkg::RTESM_RESP: begin
                if (s_axi_bready) begin
                    wr_st_d = rtesm_pkg::RTESM_IDLE;
                end
            end
            default: begin
                wr_st_d = rtesm_pkg::RTESM_IDLE;
            end
        endcase
    end

    assign s_axi_awready = (wr_st_q == rtesm_pkg::RTESM_IDLE) & ~aw_held_q;
    assign s_axi_wready  = (wr_st_q == rtesm_pkg::RTESM_IDLE) & ~w_held_q;
    assign s_axi_bvalid  = (wr_st_q == rtesm_pkg::RTESM_RESP);
    assign s_axi_bresp   = bresp_q;

    // read channel
    always_comb begin
        rd_st_d = rd_st_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        rd_go   = 1'b0;
        case (rd_st_q)
            rtesm_pkg::RTESM_IDLE: begin
                if (s_axi_arvalid) begin
                    rd_st_d = rtesm_pkg::RTESM_RESP;
                    rresp_d = rtesm_pkg::RESP_OKAY;
                    case (s_axi_araddr)
                        rtesm_pkg::OFS_STATUS: begin
                            rdata_d = status_view;
                            rd_go   = 1'b1;
                        end
                        rtesm_pkg::OFS_MASK: begin
                            rdata_d = mask_q;
                        end
                        rtesm_pkg::OFS_MASTER_EN: begin
                            rdata_d = {31'h0000_0000, master_en_q};
                        end
                        rtesm_pkg::OFS_EV_ENABLE: begin
                            rdata_d = blk_en_q;
                        end
                        rtesm_pkg::OFS_EV_CLEAR: begin
                            rdata_d = blk_stat_q;
                        end
                        default: begin
                            rdata_d = 32'h0000_0000;
                            rresp_d = rtesm_pkg::RESP_SLVERR;
                        end
                    endcase
                end
            end
            rtesm_pkg::RTESM_RESP: begin
                if (s_axi_rready) begin
                    rd_st_d = rtesm_pkg::RTESM_IDLE;
                end
            end
            default: begin
                rd_st_d = rtesm_pkg::RTESM_IDLE;
            end
        endcase
    end

    assign s_axi_arready = (rd_st_q == rtesm_pkg::RTESM_IDLE);
    assign s_axi_rvalid  = (rd_st_q == rtesm_pkg::RTESM_RESP);
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // register state
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{wstrb_q[i]}};
        end
        soft_reset  = wr_go && (awaddr_q == rtesm_pkg::OFS_SOFT_RESET)
                      && wdata_q[0] && wstrb_q[0];
        mask_d      = mask_q;
        master_en_d = master_en_q;
        blk_en_d    = blk_en_q;
        blk_stat_d  = blk_stat_q;
        // read-to-clear; an event in the same cycle survives
        status_d = rd_go ? 32'h0000_0000 : status_q;
        status_d = status_d | ev_set;
        // summary stands in bit 15 only while the irq is worked out
        status_d[rtesm_pkg::HIGH_SUM_BIT] =
            |(status_d & rtesm_pkg::HIGH_ERR_BITS);
        if (wr_go) begin
            case (awaddr_q)
                rtesm_pkg::OFS_MASK: begin
                    mask_d = ((mask_q & ~wmask) | (wdata_q & wmask))
                             & rtesm_pkg::MASK_IMPL;
                end
                rtesm_pkg::OFS_MASTER_EN: begin
                    if (wstrb_q[0]) begin
                        master_en_d = wdata_q[0];
                    end
                end
                rtesm_pkg::OFS_EV_ENABLE: begin
                    blk_en_d = (blk_en_q & ~wmask) | (wdata_q & wmask);
                end
                rtesm_pkg::OFS_EV_CLEAR: begin
                    blk_stat_d = blk_stat_q & ~(wdata_q & wmask);
                end
                default: begin
                    mask_d = mask_q;
                end
            endcase
        end
        if (soft_reset) begin
            mask_d = rtesm_pkg::MASK_RESET;
        end
        // own sticky copy of events; set wins over clear
        blk_stat_d = blk_stat_d | ev_set;
        host_irq_d = master_en_d
                     & |(status_d & mask_d);
        status_d[rtesm_pkg::HIGH_SUM_BIT] = 1'b0;
        block_irq_d = |(blk_stat_d & blk_en_d);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q      <= rtesm_pkg::MASK_RESET;
            status_q    <= 32'h0000_0000;
            master_en_q <= 1'b0;
            blk_en_q    <= 32'h0000_0000;
            blk_stat_q  <= 32'h0000_0000;
            host_irq_q  <= 1'b0;
            block_irq_q <= 1'b0;
            wr_st_q     <= rtesm_pkg::RTESM_IDLE;
            rd_st_q     <= rtesm_pkg::RTESM_IDLE;
            aw_held_q   <= 1'b0;
            w_held_q    <= 1'b0;
            awaddr_q    <= 8'h00;
            wdata_q     <= 32'h0000_0000;
            wstrb_q     <= 4'h0;
            bresp_q     <= rtesm_pkg::RESP_OKAY;
            rdata_q     <= 32'h0000_0000;
            rresp_q     <= rtesm_pkg::RESP_OKAY;
        end else begin
            mask_q      <= mask_d;
            status_q    <= status_d;
            master_en_q <= master_en_d;
            blk_en_q    <= blk_en_d;
            blk_stat_q  <= blk_stat_d;
            host_irq_q  <= host_irq_d;
            block_irq_q <= block_irq_d;
            wr_st_q     <= wr_st_d;
            rd_st_q     <= rd_st_d;
            aw_held_q   <= aw_held_d;
            w_held_q    <= w_held_d;
            awaddr_q    <= awaddr_d;
            wdata_q     <= wdata_d;
            wstrb_q     <= wstrb_d;
            bresp_q     <= bresp_d;
            rdata_q     <= rdata_d;
            rresp_q     <= rresp_d;
        end
    end

    assign host_irq  = host_irq_q;
    assign block_irq = block_irq_q;
endmodule : rtesm_top

// ### sim/rtesm_chk.sv
// checker: event, mask and interrupt relations seen at the top ports
// assumes bready held high; mask and enable are shadowed from writes
module rtesm_chk (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // write channels
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // engine strobes
    input wire logic        tx_desc_written,
    input wire logic        tx_desc_irq_flag,
    input wire logic        tx_attempt_done_ok,
    input wire logic        rx_fifo_overflow,
    input wire logic        rx_engine_running,
    input wire logic        rx_last_desc_written,
    input wire logic        rx_packet_ok,
    input wire logic        rx_desc_written,
    input wire logic        rx_desc_irq_flag,
    // interrupt
    input wire logic        host_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  a_d, a_q;
    logic [31:0] w_d, w_q, m_d, m_q;
    logic        e_d, e_q;
    // shadow lags the real register by a cycle: events kept off writes
    always_comb begin
        a_d = a_q;
        w_d = w_q;
        m_d = m_q;
        e_d = e_q;
        if (s_axi_awvalid && s_axi_awready) a_d = s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready) w_d = s_axi_wdata;
        if (s_axi_bvalid && s_axi_bready) begin
            if (a_q == rtesm_pkg::OFS_MASK) m_d = w_q & rtesm_pkg::MASK_IMPL;
            if (a_q == rtesm_pkg::OFS_MASTER_EN) e_d = w_q[0];
            if (a_q == rtesm_pkg::OFS_SOFT_RESET && w_q[0]) m_d = '0;
        end
    end
    always_ff @(posedge aclk) begin
        a_q <= aresetn ? a_d : 8'h00;
        w_q <= aresetn ? w_d : 32'h0000_0000;
        m_q <= aresetn ? m_d : 32'h0000_0000;
        e_q <= aresetn ? e_d : 1'b0;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_TX_DESC: assert property (
        tx_desc_written && tx_desc_irq_flag && e_q && m_q[7]
        |-> ##[1:2] host_irq) else $error("tx descriptor event no irq");
    AST_TX_GOOD: assert property (
        tx_attempt_done_ok && e_q && m_q[6] |-> ##[1:2] host_irq)
        else $error("tx good event no irq");
    AST_RX_OVF: assert property (
        rx_fifo_overflow && e_q && m_q[5] |-> ##[1:2] host_irq)
        else $error("rx overflow event no irq");
    AST_RX_IDLE: assert property (
        $fell(rx_engine_running) && e_q && m_q[4] |-> ##[1:3] host_irq)
        else $error("rx stop event no irq");
    AST_RX_FAIL: assert property (
        rx_last_desc_written && !rx_packet_ok && e_q && m_q[2]
        |-> ##[1:2] host_irq) else $error("rx fail event no irq");
    AST_RX_DESC: assert property (
        rx_desc_written && rx_desc_irq_flag && e_q && m_q[1]
        |-> ##[1:2] host_irq) else $error("rx descriptor event no irq");
    AST_RX_GOOD: assert property (
        rx_last_desc_written && rx_packet_ok && e_q && m_q[0]
        |-> ##[1:2] host_irq) else $error("rx good event no irq");
    AST_MASK_OFF: assert property (
        m_q == 0 |-> !$past(host_irq))
        else $error("irq with every mask bit clear");
    AST_MASTER_OFF: assert property (
        !e_q |-> !$past(host_irq))
        else $error("irq with master enable clear");
    AST_RST_IRQ: assert property (
        disable iff (1'b0) !aresetn |=> !host_irq)
        else $error("irq right after reset");
endmodule : rtesm_chk

bind rtesm_top rtesm_chk rtesm_chk_i (.*);

// ### sim/rtesm_engine_model.sv
// model of the dma engines: one command gives one cycle of strobes
// assumes go is a one-cycle request; codes 0-7 = status bit raised
module rtesm_engine_model (
    // clock, reset and command
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       go,
    input  wire logic [3:0] cmd,
    // engine strobes
    output logic            tx_desc_written,
    output logic            tx_desc_irq_flag,
    output logic            tx_attempt_done_ok,
    output logic            rx_fifo_overflow,
    output logic            rx_engine_running,
    output logic            rx_drain_bytes_met,
    output logic            rx_packet_start,
    output logic            rx_last_desc_written,
    output logic            rx_packet_ok,
    output logic            rx_desc_written,
    output logic            rx_desc_irq_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [10:0] s_d, s_q;
    // running is a level; every other strobe lasts one cycle
    always_comb begin
        s_d = {6'h00, s_q[4], 4'h0};
        if (go) begin
            case (cmd)
                4'h7: s_d[1:0] = 2'h3;
                4'h6: s_d[2] = 1'b1;
                4'h5: s_d[3] = 1'b1;
                4'h4: s_d[4] = 1'b0;
                4'h3: s_d[5] = 1'b1;
                4'h2: s_d[7] = 1'b1;
                4'h1: s_d[10:9] = 2'h3;
                4'h0: s_d[8:7] = 2'h3;
                4'h8: s_d[4] = 1'b1;
                4'h9: s_d[6] = 1'b1;
                4'hA: s_d[0] = 1'b1;
                4'hB: s_d[9] = 1'b1;
                default: ;
            endcase
        end
    end
    always_ff @(posedge aclk) begin
        s_q <= aresetn ? s_d : 11'h000;
    end
    assign {rx_desc_irq_flag, rx_desc_written, rx_packet_ok,
            rx_last_desc_written, rx_packet_start, rx_drain_bytes_met,
            rx_engine_running, rx_fifo_overflow, tx_attempt_done_ok,
            tx_desc_irq_flag, tx_desc_written} = s_q;
endmodule : rtesm_engine_model

// ### sim/rtesm_tb_top.sv
// testbench: axi4-lite master tasks, engine model, register checks
// assumes the checker is bound to rtesm_top; every wait is bounded
module rtesm_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_bready = 1'b1;
    logic        s_axi_rready = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, host_irq, block_irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd_v;
    logic        tx_desc_written, tx_desc_irq_flag, tx_attempt_done_ok;
    logic        rx_fifo_overflow, rx_engine_running, rx_drain_bytes_met;
    logic        rx_packet_start, rx_last_desc_written, rx_packet_ok;
    logic        rx_desc_written, rx_desc_irq_flag;
    logic [31:8] upper_event_set = 24'h00_0000;
    logic        go = 1'b0;
    logic [3:0]  cmd = 4'h0;
    int          fails = 0;
    int          tests_run = 0;

    always #2 aclk = ~aclk;

    rtesm_top rtesm_top_i (.*);
    rtesm_engine_model rtesm_engine_model_i (.*);

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input string n, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %08h seen %08h", n, e, g);
        end
    endtask : chk

    task automatic hang(input string n);
        fails++;
        $display("mismatch %s expected answer seen timeout", n);
        give_verdict();
    endtask : hang

    // ready and answers sampled mid-cycle, where they stand until the edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, done;
        done = 1'b0;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        repeat (40) if (!done) begin
            @(negedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            done = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        if (!done) hang("write");
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic ta, done;
        done = 1'b0;
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        repeat (40) if (!done) begin
            @(negedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            done = s_axi_rvalid;
            rd_v = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        if (!done) hang("read");
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, string n);
        rd(a);
        chk(n, e, rd_v);
    endtask : rdc

    task automatic fire(input logic [3:0] c);
        cmd <= c;
        go  <= 1'b1;
        @(posedge aclk);
        go  <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask : fire

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(rtesm_pkg::OFS_MASK, rtesm_pkg::MASK_RESET, "mask");
        rdc(rtesm_pkg::OFS_STATUS, 32'h0, "status");
        $display("test reset done");
        wr(rtesm_pkg::OFS_MASTER_EN, 32'h1);
        for (int p = 0; p < 2; p++) begin
            wr(rtesm_pkg::OFS_MASK, p ? 32'hFF : 32'h0);
            for (int i = 0; i < 8; i++) begin
                fire(4'h8);
                fire(4'h9);
                fire(i[3:0]);
                chk("irq", p, {31'h0, host_irq});
                rdc(rtesm_pkg::OFS_STATUS, 32'h1 << i, "sts");
            end
        end
        rdc(rtesm_pkg::OFS_STATUS, 32'h0, "status reread");
        $display("test events done");
        wr(rtesm_pkg::OFS_MASK, 32'h40);
        fire(4'hA);
        fire(4'hB);
        fire(4'h1);
        chk("irq masked", 32'h0, {31'h0, host_irq});
        fire(4'h6);
        chk("irq", 32'h1, {31'h0, host_irq});
        wr(rtesm_pkg::OFS_MASTER_EN, 32'h0);
        repeat (3) @(posedge aclk);
        chk("irq off", 32'h0, {31'h0, host_irq});
        wr(rtesm_pkg::OFS_MASTER_EN, 32'h1);
        repeat (3) @(posedge aclk);
        chk("irq on", 32'h1, {31'h0, host_irq});
        rdc(rtesm_pkg::OFS_STATUS, 32'h42, "status");
        repeat (3) @(posedge aclk);
        chk("irq clear", 32'h0, {31'h0, host_irq});
        fire(4'h9);
        fire(4'h3);
        fire(4'h3);
        rdc(rtesm_pkg::OFS_STATUS, 32'h8, "early once");
        $display("test masking done");
        wr(rtesm_pkg::OFS_MASK, 32'hFFFF_FFFF);
        rdc(rtesm_pkg::OFS_MASK, rtesm_pkg::MASK_IMPL, "mask bits");
        wr(rtesm_pkg::OFS_SOFT_RESET, 32'h1);
        rdc(rtesm_pkg::OFS_MASK, 32'h0, "soft reset");
        upper_event_set <= 24'h00_1000;
        @(posedge aclk);
        upper_event_set <= 24'h00_0000;
        repeat (3) @(posedge aclk);
        rdc(rtesm_pkg::OFS_STATUS, 32'h0010_8000, "summary");
        $display("test summary done");
        wr(rtesm_pkg::OFS_EV_ENABLE, 32'h1);
        fire(4'h0);
        chk("block irq", 32'h1, {31'h0, block_irq});
        wr(rtesm_pkg::OFS_EV_CLEAR, 32'hFFFF_FFFF);
        repeat (3) @(posedge aclk);
        chk("block irq clear", 32'h0, {31'h0, block_irq});
        wr(rtesm_pkg::OFS_EV_ENABLE, 32'h0);
        fire(4'h0);
        chk("block irq off", 32'h0, {31'h0, block_irq});
        rdc(rtesm_pkg::OFS_EV_CLEAR, 32'h1, "sticky");
        wr(rtesm_pkg::OFS_EV_CLEAR, 32'h1);
        rd(rtesm_pkg::OFS_STATUS);
        rdc(8'h40, 32'h0, "unmapped data");
        chk("unmapped read", {30'h0, rtesm_pkg::RESP_SLVERR}, {30'h0, rsp});
        wr(8'h40, 32'h1);
        chk("unmapped write", {30'h0, rtesm_pkg::RESP_SLVERR}, {30'h0, rsp});
        $display("test bus done");
        wr(rtesm_pkg::OFS_MASK, 32'h1);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(rtesm_pkg::OFS_MASK, 32'h0, "mask after reset");
        $display("test reset again done");
        give_verdict();
    end
endmodule : rtesm_tb_top
